// file: logic/ssp_pkg.sv
// Purpose: Shared constants for the synchronous serial shift port
// Assumes: One sys_clk cycle is one instruction cycle
// Notes:   Register map is word aligned on a 32-bit Avalon-MM slave
package ssp_pkg;

    // Clock and instruction cycle timing
    localparam int unsigned SYS_CLK_KHZ  = 10000;
    localparam int unsigned T_INSTR_NS   = 100;
    localparam int unsigned TC_CYCLES    = (T_INSTR_NS * SYS_CLK_KHZ + 999999) / 1000000;

    // Shift clock periods in instruction cycles
    localparam int unsigned SCK_PER_FAST = 2;
    localparam int unsigned SCK_PER_MID  = 4;
    localparam int unsigned SCK_PER_SLOW = 8;
    localparam logic [3:0]  HALF_FAST    = 4'((SCK_PER_FAST * TC_CYCLES) / 2);
    localparam logic [3:0]  HALF_MID     = 4'((SCK_PER_MID * TC_CYCLES) / 2);
    localparam logic [3:0]  HALF_SLOW    = 4'((SCK_PER_SLOW * TC_CYCLES) / 2);

    // Transfer length
    localparam int unsigned DATA_W       = 8;
    localparam logic [3:0]  BIT_COUNT    = 4'h8;
    localparam logic [4:0]  LAST_TOGGLE  = 5'h0F;

    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_DATA     = 8'h08;
    localparam logic [7:0]  OFF_PORTCFG  = 8'h0C;
    localparam logic [7:0]  OFF_PORTDAT  = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_EN      = 0;
    localparam int unsigned CTRL_SL_LO   = 1;
    localparam int unsigned CTRL_SL_HI   = 2;
    localparam int unsigned CTRL_IRQ_EN  = 3;
    // Status register fields
    localparam int unsigned STAT_BUSY    = 0;
    // Port configuration fields
    localparam int unsigned CFG_SO       = 4;
    localparam int unsigned CFG_SCK      = 5;
    localparam int unsigned CFG_PHASE    = 6;
    // Port data fields
    localparam int unsigned PDAT_IDLE    = 5;

    // Reset values
    localparam logic [3:0]  CTRL_RST     = 4'h0;
    localparam logic [7:0]  DATA_RST     = 8'h00;

endpackage

// file: logic/ssp_rate_if.sv
// Purpose: Link between the shift port core and its rate generator
// Assumes: Single sys_clk domain
// Notes:   tick marks each shift clock half period
`timescale 1ns/100ps
interface ssp_rate_if;
    logic       run;
    logic [1:0] rate_sel;
    logic       tick;

    modport core (output run, output rate_sel, input tick);
    modport gen  (input run, input rate_sel, output tick);
endinterface

// file: logic/ssp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs come from outside the sys_clk domain
// Notes:   Output follows once stages two and three agree
`timescale 1ns/100ps
module ssp_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] agree;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Agreed value passes at once; an extra stage would miss slow link edges
    assign agree    = ~(s2_q ^ s3_q);
    assign sync_out = (agree & s3_q) | (~agree & out_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_q <= '0;
        end else begin
            out_q <= sync_out;
        end
    end
endmodule // ssp_sync

// file: logic/ssp_rate_gen.sv
// Purpose: Shift clock half-period enable generator
// Assumes: run is low while no master transfer is in progress
// Notes:   Counter restarts whenever run drops
`timescale 1ns/100ps
module ssp_rate_gen (
    input  wire logic sys_clk,
    input  wire logic rst,
    ssp_rate_if.gen   rif
);
    logic [3:0] cnt_q;
    logic [3:0] half;
    logic       tick_q;

    always_comb begin
        case (rif.rate_sel)
            2'h0:    half = ssp_pkg::HALF_FAST;
            2'h1:    half = ssp_pkg::HALF_MID;
            default: half = ssp_pkg::HALF_SLOW;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (!rif.run) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == half - 4'h1) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    assign rif.tick = tick_q & rif.run;
endmodule // ssp_rate_gen

// file: logic/ssp_top.sv
// Purpose: Eight-bit synchronous serial shift port, master or slave
// Assumes: sys_clk is the instruction cycle clock; pins resolved outside
// Notes:   Registers reached over Avalon-MM with one wait cycle
// Notes on behaviour
// - Eight-bit shift register exchanges data on serial in, serial out, shift clock.
// - Internal shift clock means master; external shift clock means slave.
// - Interface works only while serial_enable is one.
// - Master clock period: 00 two, 01 four, high select eight cycles.
// - Setting busy starts shifting; busy clears after eight bits.
// - Clearing busy early stops shifting with fewer bits moved.
// - Enabled interrupt fires when a full eight-bit transfer completes.
// - Master generates the clock and starts every exchange.
// - Serial out config drives or floats output; clock config picks master.
// - After eight clock pulses busy clears and shifting stops.
// - Normal phase samples on rising, shifts out on falling; alternate reverses.
// - Clock idle level equals port data bit five.
// - Effective phase is phase select XOR idle polarity.
// - Phase select resets to zero, normal clock.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module ssp_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    input  wire logic        shift_clock_in,
    output logic             shift_clock_out,
    output logic             shift_clock_oe,
    output logic             xfer_done_irq
);
    ssp_rate_if rif ();

    logic [31:0] rdata_q;
    logic        ack_q;
    logic        req;
    logic        wr_go;
    logic [3:0]  ctrl_q;
    logic        so_cfg_q;
    logic        sck_cfg_q;
    logic        phase_q;
    logic        idle_pol_q;
    logic [7:0]  sreg_q;
    logic        out_q;
    logic        busy_q;
    logic [3:0]  bit_cnt_q;
    logic [4:0]  tog_cnt_q;
    logic        sck_q;
    logic        prev_q;
    logic        irq_q;
    logic [1:0]  sync_v;
    logic        si_s;
    logic        sck_s;
    logic        enabled;
    logic        master;
    logic        alt;
    logic        rise;
    logic        fall;
    logic        smp_edge;
    logic        sft_edge;
    logic        m_done;
    logic        s_done;
    logic        done;
    logic        busy_wr;
    logic        lane0;

    ssp_sync #(
        .WIDTH    (2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({shift_clock_in, serial_in}),
        .sync_out (sync_v)
    );

    ssp_rate_gen u_rate (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rif     (rif.gen)
    );

    assign si_s  = sync_v[0];
    assign sck_s = sync_v[1];

    // Bus handshake: one wait cycle, then answer
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign lane0           = avs_byteenable[0];
    assign avs_readdata    = rdata_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                ssp_pkg::OFF_CTRL:    rdata_q <= {28'h000_0000, ctrl_q};
                ssp_pkg::OFF_STATUS:  rdata_q <= {31'h0, busy_q};
                ssp_pkg::OFF_DATA:    rdata_q <= {24'h00_0000, sreg_q};
                ssp_pkg::OFF_PORTCFG: rdata_q <= {25'h0, phase_q, sck_cfg_q,
                                                  so_cfg_q, 4'h0};
                ssp_pkg::OFF_PORTDAT: rdata_q <= {26'h0, idle_pol_q, 5'h00};
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q     <= ssp_pkg::CTRL_RST;
            so_cfg_q   <= 1'b0;
            sck_cfg_q  <= 1'b0;
            phase_q    <= 1'b0;
            idle_pol_q <= 1'b0;
        end else if (wr_go && lane0) begin
            case (avs_address)
                ssp_pkg::OFF_CTRL: begin
                    ctrl_q <= avs_writedata[3:0];
                end
                ssp_pkg::OFF_PORTCFG: begin
                    so_cfg_q  <= avs_writedata[ssp_pkg::CFG_SO];
                    sck_cfg_q <= avs_writedata[ssp_pkg::CFG_SCK];
                    phase_q   <= avs_writedata[ssp_pkg::CFG_PHASE];
                end
                ssp_pkg::OFF_PORTDAT: begin
                    idle_pol_q <= avs_writedata[ssp_pkg::PDAT_IDLE];
                end
                default: begin
                end
            endcase
        end
    end

    assign enabled = ctrl_q[ssp_pkg::CTRL_EN];
    assign master  = sck_cfg_q;
    assign alt     = phase_q ^ idle_pol_q;

    // Rate generator runs only during a master transfer
    assign rif.run      = busy_q & master & enabled;
    assign rif.rate_sel = ctrl_q[ssp_pkg::CTRL_SL_HI] ? 2'h2 :
                          {1'b0, ctrl_q[ssp_pkg::CTRL_SL_LO]};

    // Edges of the shift clock, internal or external
    always_comb begin
        if (master) begin
            rise = rif.tick & ~sck_q;
            fall = rif.tick & sck_q;
        end else begin
            rise = busy_q & sck_s & ~prev_q;
            fall = busy_q & ~sck_s & prev_q;
        end
    end

    assign smp_edge = alt ? fall : rise;
    assign sft_edge = alt ? rise : fall;

    assign m_done  = master & rif.tick & (tog_cnt_q == ssp_pkg::LAST_TOGGLE);
    assign s_done  = ~master & smp_edge & (bit_cnt_q == ssp_pkg::BIT_COUNT - 4'h1);
    assign done    = busy_q & enabled & (m_done | s_done);
    assign busy_wr = wr_go & lane0 & (avs_address == ssp_pkg::OFF_STATUS);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sck_s;
        end
    end

    // Master shift clock level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_q <= 1'b0;
        end else if (!rif.run) begin
            sck_q <= idle_pol_q;
        end else if (rif.tick) begin
            sck_q <= ~sck_q;
        end
    end

    // Busy flag: software write wins over completion
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (!enabled) begin
            busy_q <= 1'b0;
        end else if (busy_wr) begin
            busy_q <= avs_writedata[ssp_pkg::STAT_BUSY];
        end else if (done) begin
            busy_q <= 1'b0;
        end
    end

    // Bit and toggle counters restart on every busy write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= 4'h0;
            tog_cnt_q <= 5'h00;
        end else if (busy_wr || !busy_q) begin
            bit_cnt_q <= 4'h0;
            tog_cnt_q <= 5'h00;
        end else begin
            if (smp_edge) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (rif.tick) begin
                tog_cnt_q <= tog_cnt_q + 5'h01;
            end
        end
    end

    // Shift register and output bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sreg_q <= ssp_pkg::DATA_RST;
            out_q  <= 1'b0;
        end else if (wr_go && lane0 && avs_address == ssp_pkg::OFF_DATA) begin
            sreg_q <= avs_writedata[7:0];
            out_q  <= avs_writedata[7];
        end else if (busy_q && enabled) begin
            if (smp_edge) begin
                sreg_q <= {sreg_q[6:0], si_s};
            end
            if (sft_edge) begin
                out_q <= sreg_q[7];
            end
        end
    end

    // Completion pulse, only for a full eight-bit transfer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done & ~busy_wr & ctrl_q[ssp_pkg::CTRL_IRQ_EN];
        end
    end

    assign xfer_done_irq   = irq_q;
    assign serial_out      = out_q;
    assign serial_out_oe   = enabled & so_cfg_q;
    assign shift_clock_out = sck_q;
    assign shift_clock_oe  = enabled & sck_cfg_q;
endmodule // ssp_top

// file: sim/ssp_top_assertions.sv
// Purpose: Port-level assertions for ssp_top
// Assumes: Register shadows follow completed bus writes
// Notes:   Link checks apply while the clock pin is an output
`timescale 1ns/100ps
module ssp_top_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        serial_out,
    input wire logic        serial_out_oe,
    input wire logic        shift_clock_out,
    input wire logic        shift_clock_oe,
    input wire logic        xfer_done_irq
);
    logic [3:0] ctl_q;
    logic [2:0] cfg_q;
    logic       pol_q;
    logic [4:0] tog_q;
    logic       wr_ok;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 4'h0;
            cfg_q <= 3'h0;
            pol_q <= 1'b0;
        end else if (wr_ok) begin
            case (avs_address)
                ssp_pkg::OFF_CTRL:    ctl_q <= avs_writedata[3:0];
                ssp_pkg::OFF_PORTCFG: cfg_q <= avs_writedata[6:4];
                ssp_pkg::OFF_PORTDAT: pol_q <= avs_writedata[5];
                default:              ctl_q <= ctl_q;
            endcase
        end
    end
    // Clock toggles since the last start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tog_q <= 5'h00;
        end else if (wr_ok && avs_address == ssp_pkg::OFF_STATUS) begin
            tog_q <= 5'h00;
        end else if ($changed(shift_clock_out)) begin
            tog_q <= tog_q + 5'h01;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("waitrequest too long");
    AST_SO_OE: assert property (serial_out_oe == (ctl_q[0] && cfg_q[0]))
        else $error("serial out enable wrong");
    AST_SCK_OE: assert property (shift_clock_oe == (ctl_q[0] && cfg_q[1]))
        else $error("clock enable wrong");
    AST_IRQ_ONE: assert property (xfer_done_irq |=> !xfer_done_irq)
        else $error("irq longer than a cycle");
    AST_IRQ_EN: assert property (xfer_done_irq |-> ctl_q[3] && ctl_q[0])
        else $error("irq while masked");
    AST_IRQ_TOG: assert property (xfer_done_irq && cfg_q[1] |=> tog_q == 5'h10)
        else $error("transfer not sixteen clock edges");
    AST_IDLE: assert property (xfer_done_irq && cfg_q[1]
        |-> (shift_clock_out == pol_q)[*3]) else $error("clock not idle after transfer");
    AST_SAMPLE: assert property (cfg_q[1] && $changed(shift_clock_out)
        && shift_clock_out == !(cfg_q[2] ^ pol_q) |-> $stable(serial_out))
        else $error("data changed on sample edge");
endmodule // ssp_top_chk

bind ssp_top ssp_top_chk u_chk (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_waitrequest, .serial_out, .serial_out_oe,
    .shift_clock_out, .shift_clock_oe, .xfer_done_irq
);

// file: sim/ssp_peer.sv
// Purpose: Far-side shift partner, slave or clock source
// Assumes: eff is phase select XOR idle polarity
// Notes:   As clock source it sends 8 bits at an 800 ns period
`timescale 1ns/100ps
module ssp_peer (
    input  wire logic       sck_line,
    input  wire logic       mosi,
    input  wire logic       pol,
    input  wire logic       eff,
    input  wire logic       ld,
    input  wire logic [7:0] tx,
    output logic            sck_peer,
    output logic            miso,
    output logic      [7:0] rx
);
    logic [7:0] sh  = 8'h00;
    logic       tog = 1'b0;
    assign sck_peer = pol ^ tog;
    initial rx = 8'h00;
    initial miso = 1'b0;
    always @(posedge ld or posedge sck_line or negedge sck_line) begin
        if (ld) begin
            sh   = tx;
            miso = tx[7];
        end else if (sck_line == !eff) begin
            rx = {rx[6:0], mosi};
            sh = {sh[6:0], 1'b0};
        end else begin
            miso = sh[7];
        end
    end
    // Clock stands still outside the frame
    task automatic run_frame();
        #37;
        repeat (16) #400 tog = !tog;
        #400;
    endtask
endmodule // ssp_peer

// file: sim/tb_sync_serial_shift_port.sv
// Purpose: Self-checking bench for the serial shift port
// Assumes: Bus slave answers after one wait cycle
// Notes:   Interrupting master transfers come from a table; abort, masked and slave by hand
`timescale 1ns/100ps
module tb_sync_serial_shift_port;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cfg;
        logic [7:0] pd;
        logic [7:0] tx;
        logic [7:0] ptx;
        logic [3:0] h;
    } ssp_row_t;
    logic        sys_clk        = 1'b0;
    logic        rst            = 1'b1;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        serial_in;
    logic        shift_clock_in;
    logic        pol            = 1'b0;
    logic        eff            = 1'b0;
    logic        ld             = 1'b0;
    logic [7:0]  ptx            = 8'h00;
    logic [31:0] avs_readdata, rq;
    logic        avs_waitrequest, serial_out, serial_out_oe, shift_clock_out;
    logic        shift_clock_oe, xfer_done_irq, sck_peer, miso, sck_line, so_line;
    logic [7:0]  rx8;
    int          cyc = 0, irq_n = 0, irq0, n, num_errors = 0, n_checks = 0;
    logic [7:0]  adr [6] = '{8'h40, 8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    ssp_row_t    rows [4] = '{'{8'h09, 8'h30, 8'h00, 8'hA5, 8'h3C, 4'h1},
        '{8'h0B, 8'h70, 8'h00, 8'h81, 8'h7E, 4'h2},
        '{8'h0D, 8'h30, 8'h20, 8'h5A, 8'hC3, 4'h4},
        '{8'h0F, 8'h70, 8'h20, 8'h01, 8'hFF, 4'h4}};
    ssp_top DUT (
        .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_in, .serial_out,
        .serial_out_oe, .shift_clock_in, .shift_clock_out, .shift_clock_oe, .xfer_done_irq
    );
    ssp_peer PEER (
        .sck_line, .mosi(so_line), .pol, .eff, .ld, .tx(ptx), .sck_peer, .miso, .rx(rx8)
    );
    assign sck_line = shift_clock_oe ? shift_clock_out : sck_peer;
    assign so_line  = serial_out_oe ? serial_out : cyc[0];
    // Far-side pins reach the design unclocked, as on a real board
    assign serial_in      = miso;
    assign shift_clock_in = sck_line;
    always #50 sys_clk = !sys_clk;
    always @(posedge sys_clk) begin
        cyc            <= cyc + 1;
        if (xfer_done_irq === 1'b1) irq_n <= irq_n + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        logic w;
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
            w = avs_waitrequest;
            q = avs_readdata;
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic setup(input ssp_row_t r);
        bus(1'b1, ssp_pkg::OFF_CTRL, r.ctl, rq);
        bus(1'b1, ssp_pkg::OFF_PORTCFG, r.cfg, rq);
        bus(1'b1, ssp_pkg::OFF_PORTDAT, r.pd, rq);
        bus(1'b1, ssp_pkg::OFF_DATA, r.tx, rq);
        pol = r.pd[5];
        eff = r.cfg[6] ^ r.pd[5];
        ptx = r.ptx;
        ld  = 1'b1;
        @(posedge sys_clk);
        ld  = 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b1, 8'h40, 8'hFF, rq);
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 8'h00, rq);
            chk(rq, 32'h0);
        end
        foreach (rows[i]) begin
            setup(rows[i]);
            bus(1'b1, ssp_pkg::OFF_STATUS, 8'h01, rq);
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
            end while (xfer_done_irq !== 1'b1 && n < 200);
            @(posedge sys_clk);
            chk(32'(n >= 16 * rows[i].h - 3 && n <= 16 * rows[i].h + 4), 32'h1);
            bus(1'b0, ssp_pkg::OFF_STATUS, 8'h00, rq);
            chk(rq, 32'h0);
            chk(rx8, rows[i].tx);
            bus(1'b0, ssp_pkg::OFF_DATA, 8'h00, rq);
            if (rows[i].h == 4'h4) chk(rq, rows[i].ptx);
            chk(shift_clock_out, rows[i].pd[5]);
            chk({serial_out_oe, shift_clock_oe}, 2'b11);
        end
        // Abort part way, then a masked transfer
        irq0 = irq_n;
        setup('{8'h0D, 8'h30, 8'h00, 8'hF0, 8'h0F, 4'h4});
        bus(1'b1, ssp_pkg::OFF_STATUS, 8'h01, rq);
        repeat (20) @(posedge sys_clk);
        bus(1'b1, ssp_pkg::OFF_STATUS, 8'h00, rq);
        repeat (100) @(posedge sys_clk);
        chk(irq_n, irq0);
        chk(shift_clock_out, 1'b0);
        setup('{8'h05, 8'h30, 8'h00, 8'h3C, 8'h96, 4'h4});
        bus(1'b1, ssp_pkg::OFF_STATUS, 8'h01, rq);
        repeat (90) @(posedge sys_clk);
        bus(1'b0, ssp_pkg::OFF_STATUS, 8'h00, rq);
        chk(rq, 32'h0);
        chk(rx8, 8'h3C);
        chk(irq_n, irq0);
        // Slave: far side clocks the frame
        setup('{8'h09, 8'h10, 8'h00, 8'h96, 8'h4B, 4'h0});
        bus(1'b1, ssp_pkg::OFF_STATUS, 8'h01, rq);
        PEER.run_frame();
        repeat (9) @(posedge sys_clk);
        chk(irq_n, irq0 + 1);
        chk(rx8, 8'h96);
        chk(shift_clock_oe, 1'b0);
        bus(1'b0, ssp_pkg::OFF_DATA, 8'h00, rq);
        chk(rq, 32'h4B);
        bus(1'b1, ssp_pkg::OFF_PORTCFG, 8'h30, rq);
        bus(1'b1, ssp_pkg::OFF_CTRL, 8'h00, rq);
        bus(1'b1, ssp_pkg::OFF_STATUS, 8'h01, rq);
        repeat (20) @(posedge sys_clk);
        chk({serial_out_oe, shift_clock_oe, shift_clock_out}, 3'b000);
        finish_test();
    end
endmodule // tb_sync_serial_shift_port
